// ---- design/spcr_pkg.sv ----
// Constants and types of the serial port configuration registers
package spcr_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [12:0] ADDR_SETUP    = 13'h0000;
	localparam logic [12:0] ADDR_VARIANT  = 13'h0003;
	localparam logic [12:0] ADDR_RB_SEL   = 13'h0004;
	localparam logic [12:0] ADDR_UPDATE   = 13'h0232;

	localparam logic [7:0]  SETUP_RST     = 8'h18;
	localparam logic [7:0]  RB_SEL_RST    = 8'h00;

	// ------------------------------------------------------------------
	// Instruction and byte framing
	// ------------------------------------------------------------------
	localparam logic [3:0]  INSTR_LAST    = 4'hf;
	localparam logic [3:0]  BYTE_LAST     = 4'h7;
	localparam int          INSTR_RW_BIT  = 15;
	localparam int          RB_SEL_BIT    = 0;
	localparam int          UPDATE_BIT    = 0;

	// Setup register fields, bit 7 down to bit 0
	typedef struct packed {
		logic [3:0] mirror;
		logic       long_instr;
		logic       soft_reset;
		logic       lsb_first;
		logic       four_wire;
	} spcr_setup_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INSTR,
		ST_DATA
	} spcr_state_t;

endpackage

// ---- design/spcr_top.sv ----
// Serial control port with setup, identifier and readback bank registers
`timescale 1ns/1ns
module spcr_top
	import spcr_pkg::*;
#(
	// Arbitrary value, no real part implied
	parameter logic [7:0] VARIANT_ID = 8'h5a
)
(
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic sdio_in,
	output logic      sdio_out,
	output logic      sdio_oe,
	output logic      serial_output_pin,
	output logic      serial_output_pin_oe,
	output logic      lsb_first,
	output logic      four_wire_select,
	output logic      readback_active
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] sclk_q;
	logic [2:0] cs_q;
	logic [1:0] sdi_q;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_q <= 3'h0;
			cs_q   <= 3'h7;
			sdi_q  <= 2'h0;
		end
		else
		begin
			sclk_q <= {sclk_q[1:0], sclk};
			cs_q   <= {cs_q[1:0], cs_n};
			sdi_q  <= {sdi_q[0], sdio_in};
		end
	end

	// Only the second and third stages feed logic
	logic sclk_rise;
	logic sclk_fall;
	logic cs_high;
	logic cs_end;
	logic sdi;

	assign sclk_rise = sclk_q[1] & ~sclk_q[2];
	assign sclk_fall = ~sclk_q[1] & sclk_q[2];
	assign cs_high   = cs_q[1];
	assign cs_end    = cs_q[1] & ~cs_q[2];
	assign sdi       = sdi_q[1];

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	function automatic logic [15:0] shift_in(input logic [15:0] v,
		input logic d, input logic lsb, input logic wide);
		logic [15:0] r;
		r = v;
		if (!lsb)
			r = {v[14:0], d};
		else if (wide)
			r = {d, v[15:1]};
		else
			r = {8'h00, d, v[7:1]};
		return r;
	endfunction

	function automatic logic [12:0] step_addr(input logic [12:0] a,
		input logic lsb);
		return lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	spcr_state_t state;
	spcr_state_t next_state;
	spcr_setup_t setup;
	spcr_setup_t next_setup;
	spcr_setup_t pend;
	spcr_setup_t next_pend;
	logic        pend_v;
	logic        next_pend_v;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [15:0] sh;
	logic [15:0] next_sh;
	logic        rd;
	logic        next_rd;
	logic [12:0] addr;
	logic [12:0] next_addr;
	logic [7:0]  buf_rb;
	logic [7:0]  next_buf_rb;
	logic [7:0]  act_rb;
	logic [7:0]  next_act_rb;
	logic        upd;
	logic        next_upd;
	logic [7:0]  tx;
	logic [7:0]  next_tx;
	logic        obit;
	logic        next_obit;
	logic        oe_io;
	logic        next_oe_io;
	logic        oe_so;
	logic        next_oe_so;

	// Readback multiplexer
	function automatic logic [7:0] read_reg(input logic [12:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			ADDR_SETUP:   r = setup;
			ADDR_VARIANT: r = VARIANT_ID;
			ADDR_RB_SEL:  r = act_rb[RB_SEL_BIT] ? act_rb : buf_rb;
			default:      r = 8'h00;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb
	begin
		logic [7:0] v;
		v           = 8'h00;
		next_state  = state;
		next_setup  = setup;
		next_pend   = pend;
		next_pend_v = pend_v;
		next_cnt    = cnt;
		next_sh     = sh;
		next_rd     = rd;
		next_addr   = addr;
		next_buf_rb = buf_rb;
		next_act_rb = act_rb;
		next_upd    = 1'b0;
		next_tx     = tx;
		next_obit   = obit;
		next_oe_io  = oe_io;
		next_oe_so  = oe_so;
		if (upd)
			next_act_rb = buf_rb;
		if (cs_high)
		begin
			next_state = ST_IDLE;
			next_oe_io = 1'b0;
			next_oe_so = 1'b0;
			if (cs_end && pend_v)
			begin
				next_setup  = pend;
				next_pend_v = 1'b0;
			end
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					next_state = ST_INSTR;
					next_cnt   = 4'h0;
				end
				ST_INSTR:
				begin
					if (sclk_rise)
					begin
						next_sh  = shift_in(sh, sdi, setup.lsb_first, 1'b1);
						next_cnt = cnt + 4'h1;
						if (cnt == INSTR_LAST)
						begin
							next_state = ST_DATA;
							next_cnt   = 4'h0;
							next_rd    = next_sh[INSTR_RW_BIT];
							next_addr  = next_sh[12:0];
							next_sh    = 16'h0000;
						end
					end
				end
				ST_DATA:
				begin
					if (rd && sclk_fall)
					begin
						v = (cnt == 4'h0) ? read_reg(addr) : tx;
						next_obit = setup.lsb_first ? v[0] : v[7];
						next_tx   = setup.lsb_first ? {1'b0, v[7:1]}
							: {v[6:0], 1'b0};
						next_oe_io = ~setup.four_wire;
						next_oe_so = setup.four_wire;
					end
					if (sclk_rise)
					begin
						next_sh  = shift_in(sh, sdi, setup.lsb_first, 1'b0);
						next_cnt = cnt + 4'h1;
						if (cnt == BYTE_LAST)
						begin
							next_cnt = 4'h0;
							next_addr = step_addr(addr, setup.lsb_first);
							if (!rd)
							begin
								case (addr)
									ADDR_SETUP:
									begin
										next_pend   = next_sh[7:0];
										next_pend_v = 1'b1;
									end
									ADDR_RB_SEL:
										next_buf_rb = next_sh[7:0];
									ADDR_UPDATE:
										next_upd = next_sh[UPDATE_BIT];
									default:
										next_upd = 1'b0;
								endcase
							end
						end
					end
				end
				default:
					next_state = ST_IDLE;
			endcase
		end
		// Held at defaults until the host clears it
		if (setup.soft_reset)
		begin
			next_buf_rb = RB_SEL_RST;
			next_act_rb = RB_SEL_RST;
			next_upd    = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state  <= ST_IDLE;
			setup  <= SETUP_RST;
			pend   <= SETUP_RST;
			pend_v <= 1'b0;
			cnt    <= 4'h0;
			sh     <= 16'h0000;
			rd     <= 1'b0;
			addr   <= 13'h0000;
			buf_rb <= RB_SEL_RST;
			act_rb <= RB_SEL_RST;
			upd    <= 1'b0;
			tx     <= 8'h00;
			obit   <= 1'b0;
			oe_io  <= 1'b0;
			oe_so  <= 1'b0;
		end
		else
		begin
			state  <= next_state;
			setup  <= next_setup;
			pend   <= next_pend;
			pend_v <= next_pend_v;
			cnt    <= next_cnt;
			sh     <= next_sh;
			rd     <= next_rd;
			addr   <= next_addr;
			buf_rb <= next_buf_rb;
			act_rb <= next_act_rb;
			upd    <= next_upd;
			tx     <= next_tx;
			obit   <= next_obit;
			oe_io  <= next_oe_io;
			oe_so  <= next_oe_so;
		end
	end

	assign sdio_out             = obit;
	assign sdio_oe              = oe_io;
	assign serial_output_pin    = obit;
	assign serial_output_pin_oe = oe_so;
	assign lsb_first            = setup.lsb_first;
	assign four_wire_select     = setup.four_wire;
	assign readback_active      = act_rb[RB_SEL_BIT];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence s_byte_done;
		state == ST_DATA && !cs_high && sclk_rise && cnt == BYTE_LAST;
	endsequence

	a_instr_length: assert property (
		state == ST_INSTR && !cs_high && sclk_rise && cnt == INSTR_LAST
		|=> state == ST_DATA && cnt == 4'h0)
		else $error("instruction not 16 bits");
	a_soft_defaults: assert property (
		setup.soft_reset |=> buf_rb == RB_SEL_RST && act_rb == RB_SEL_RST)
		else $error("soft reset left registers set");
	a_soft_sticky: assert property (
		setup.soft_reset && !cs_end |=> setup.soft_reset)
		else $error("soft reset cleared itself");
	a_addr_down: assert property (
		s_byte_done ##0 !setup.lsb_first |=> addr == 13'($past(addr) - 1))
		else $error("address did not decrement");
	a_addr_up: assert property (
		s_byte_done ##0 setup.lsb_first |=> addr == 13'($past(addr) + 1))
		else $error("address did not increment");
	a_three_wire: assert property (
		!setup.four_wire && !cs_end |=> !serial_output_pin_oe)
		else $error("output pin driven in three-wire mode");
	a_four_wire: assert property (
		setup.four_wire && !cs_end |=> !sdio_oe)
		else $error("data pin driven in four-wire mode");
	a_update_copy: assert property (
		upd && !setup.soft_reset |=> act_rb == $past(buf_rb) && !upd)
		else $error("update did not copy or clear");
	a_mode_frame: assert property (
		!cs_end |=> $stable(setup))
		else $error("setup changed inside a frame");

endmodule

// ---- verification/spcr_host.sv ----
// Host controller model driving the serial control port
`timescale 1ns/1ns
module spcr_host
	import spcr_pkg::*;
(
	input  wire logic mclk,
	input  wire logic lsb,
	input  wire logic four,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	input  wire logic so_pin,
	input  wire logic so_oe,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio_in,
	output logic [7:0] bad_oe
);
	logic h_en;
	logic h_d;

	// ------------------------------------------------------------------
	// Pin levels
	// ------------------------------------------------------------------
	// Released line shows the inverse, never a stale value
	assign sdio_in = sdio_oe ? sdio_out : (h_en ? h_d : ~h_d);

	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		h_en = 1'b0;
		h_d = 1'b0;
		bad_oe = 8'h00;
	end

	always @(posedge mclk)
		if ((sdio_oe && four) || (so_oe && !four))
			bad_oe <= bad_oe + 8'h01;

	// ------------------------------------------------------------------
	// One frame, mode 0, sclk idle low between frames
	// ------------------------------------------------------------------
	task automatic xfer(input logic rd, input logic [12:0] addr,
		input logic [15:0] wd, input int nb, output logic [15:0] rdat);
		logic [15:0] ins;
		int k;
		int j;
		int i;
		ins = {rd, 2'b00, addr};
		rdat = 16'h0000;
		cs_n <= 1'b0;
		repeat (8) @(posedge mclk);
		for (k = 0; k < 16 + 8 * nb; k++)
		begin
			j = (k < 16) ? 0 : k - 16;
			i = j - j % 8 + (lsb ? j % 8 : 7 - j % 8);
			sclk <= 1'b0;
			h_en <= (k < 16) || !rd;
			h_d <= (k < 16) ? ins[lsb ? k : 15 - k] : wd[i];
			repeat (8) @(posedge mclk);
			if (k >= 16)
				rdat[i] = four ? (so_oe ? so_pin : ~so_pin) : sdio_in;
			sclk <= 1'b1;
			repeat (8) @(posedge mclk);
		end
		sclk <= 1'b0;
		h_en <= 1'b0;
		repeat (8) @(posedge mclk);
		cs_n <= 1'b1;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ---- verification/serial_port_config_regs_bench.sv ----
// Self-checking bench for the serial port configuration registers
`timescale 1ns/1ns
module serial_port_config_regs_bench
	import spcr_pkg::*;
;
	// Arbitrary value, no real part implied
	localparam logic [7:0] VID = 8'h6c;

	logic        mclk;
	logic        arst_n;
	logic        sclk;
	logic        cs_n;
	logic        sdio_in;
	logic        sdio_out;
	logic        sdio_oe;
	logic        so_pin;
	logic        so_oe;
	logic        lsb_first;
	logic        four_wire_select;
	logic        readback_active;
	logic        lsb;
	logic        four;
	logic [7:0]  bad_oe;
	logic [15:0] rd;
	int          failures;
	int          comparisons;
	int          cycles;

	spcr_top #(.VARIANT_ID(VID)) i_dut (
		.mclk                 (mclk),
		.arst_n               (arst_n),
		.sclk                 (sclk),
		.cs_n                 (cs_n),
		.sdio_in              (sdio_in),
		.sdio_out             (sdio_out),
		.sdio_oe              (sdio_oe),
		.serial_output_pin    (so_pin),
		.serial_output_pin_oe (so_oe),
		.lsb_first            (lsb_first),
		.four_wire_select     (four_wire_select),
		.readback_active      (readback_active)
	);

	spcr_host i_host (
		.mclk     (mclk),
		.lsb      (lsb),
		.four     (four),
		.sdio_out (sdio_out),
		.sdio_oe  (sdio_oe),
		.so_pin   (so_pin),
		.so_oe    (so_oe),
		.sclk     (sclk),
		.cs_n     (cs_n),
		.sdio_in  (sdio_in),
		.bad_oe   (bad_oe)
	);

	// ------------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		cycles = 0;
	end
	always #5 mclk = ~mclk;

	// Ceiling well above some thirty frames of about 420 cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		i_host.xfer(1'b0, a, {8'h00, d}, 1, rd);
	endtask

	task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
		i_host.xfer(1'b1, a, 16'h0000, 1, rd);
		chk_byte(rd[7:0], exp);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		failures = 0;
		comparisons = 0;
		lsb = 1'b0;
		four = 1'b0;
		arst_n = 1'b0;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		chk_bit(lsb_first, 1'b0);
		chk_bit(four_wire_select, 1'b0);
		rdchk(ADDR_SETUP, SETUP_RST);
		rdchk(ADDR_VARIANT, VID);
		wr(ADDR_VARIANT, ~VID);
		rdchk(ADDR_VARIANT, VID);
		wr(ADDR_RB_SEL, 8'h01);
		rdchk(ADDR_RB_SEL, 8'h01);
		chk_bit(readback_active, 1'b0);
		wr(ADDR_UPDATE, 8'h01);
		chk_bit(readback_active, 1'b1);
		rdchk(ADDR_UPDATE, 8'h00);
		wr(ADDR_RB_SEL, 8'h00);
		rdchk(ADDR_RB_SEL, 8'h01);
		wr(ADDR_UPDATE, 8'h01);
		rdchk(ADDR_RB_SEL, 8'h00);
		i_host.xfer(1'b1, ADDR_RB_SEL, 16'h0000, 2, rd);
		chk_byte(rd[15:8], VID);
		wr(ADDR_SETUP, 8'h5a);
		chk_bit(lsb_first, 1'b1);
		lsb = 1'b1;
		rdchk(ADDR_SETUP, 8'h5a);
		i_host.xfer(1'b0, ADDR_VARIANT, 16'h01a5, 2, rd);
		rdchk(ADDR_RB_SEL, 8'h01);
		i_host.xfer(1'b1, ADDR_VARIANT, 16'h0000, 2, rd);
		chk_byte(rd[7:0], VID);
		chk_byte(rd[15:8], 8'h01);
		wr(ADDR_SETUP, SETUP_RST);
		lsb = 1'b0;
		chk_bit(lsb_first, 1'b0);
		wr(ADDR_SETUP, 8'h99);
		chk_bit(four_wire_select, 1'b1);
		four = 1'b1;
		rdchk(ADDR_VARIANT, VID);
		wr(ADDR_SETUP, SETUP_RST);
		four = 1'b0;
		chk_bit(four_wire_select, 1'b0);
		wr(ADDR_UPDATE, 8'h01);
		chk_bit(readback_active, 1'b1);
		wr(ADDR_SETUP, 8'h3c);
		chk_bit(readback_active, 1'b0);
		rdchk(ADDR_SETUP, 8'h3c);
		wr(ADDR_RB_SEL, 8'h01);
		rdchk(ADDR_RB_SEL, 8'h00);
		wr(ADDR_SETUP, SETUP_RST);
		rdchk(ADDR_RB_SEL, 8'h00);
		wr(ADDR_RB_SEL, 8'h01);
		rdchk(ADDR_RB_SEL, 8'h01);
		chk_byte(bad_oe, 8'h00);
		tally_and_finish();
	end
endmodule
